// *** hw/ocs_regs.vh ***
`ifndef OCS_REGS_VH
`define OCS_REGS_VH
// Register offsets on the plain register port
`define OCS_REG_DISP 3'h0
`define OCS_REG_FRINGE 3'h1
`define OCS_REG_TA_START 3'h2
`define OCS_REG_TA_END 3'h3
`define OCS_REG_STATUS 3'h4
// Display control fields
`define OCS_DISP_MODE_LSB 0
`define OCS_DISP_SCR_LSB 2
`define OCS_DISP_FLF_BIT 6
// Fringe control fields (bit 0 north, 1 south, 2 east, 3 west)
`define OCS_FR_DIR_LSB 0
`define OCS_FR_COL_LSB 4
// Reset values
`define OCS_DISP_RST 8'h00
`define OCS_FRINGE_RST 8'h00
`define OCS_TA_START_RST 8'h00
`define OCS_TA_END_RST 8'h28
// Screen display modes
`define OCS_MODE_VIDEO 2'h0
`define OCS_MODE_TEXT 2'h1
`define OCS_MODE_MIXSCR 2'h2
`define OCS_MODE_MIXVID 2'h3
// Display word fields
`define OCS_W_SERIAL 11
`define OCS_W_SMODE 10
// Row-start defaults
`define OCS_DEF_FG 3'h0
`define OCS_DEF_BG 4'h8
// Flash half periods and pixel clock rate
`define OCS_CLK_KHZ 25'd40000
`define OCS_FLASH_HALF_SLOW_MS 25'd500
`define OCS_FLASH_HALF_FAST_MS 25'd250
`define OCS_FLASH_SLOW_CYC (`OCS_FLASH_HALF_SLOW_MS * `OCS_CLK_KHZ)
`define OCS_FLASH_FAST_CYC (`OCS_FLASH_HALF_FAST_MS * `OCS_CLK_KHZ)
`endif

// *** hw/ocs_flash_timer.v ***
`default_nettype none
module ocs_flash_timer #(
  parameter [24:0] SLOW_CYC = 25'd20000000,
  parameter [24:0] FAST_CYC = 25'd10000000
) (
  input wire sys_clk, // Pixel clock
  input wire sys_rst, // Async reset, high
  input wire ce, // Clock enable
  input wire fast, // 1: about 2 Hz, 0: about 1 Hz
  output reg phase_q // Flash phase, 1 = shown
);
  reg [24:0] cnt_q; // Half-period counter
  wire [24:0] half_w; // Selected half period
  assign half_w = fast ? FAST_CYC : SLOW_CYC;
  // Equal on and off halves give a 50% ratio
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= 25'h0000000;
      phase_q <= 1'b1;
    end
    else if (ce)
    begin
      // A change to the fast rate mid-period ends the half early; to the slow rate it lengthens it
      if (cnt_q >= half_w - 25'd1)
      begin
        cnt_q <= 25'h0000000;
        phase_q <= ~phase_q;
      end
      else
        cnt_q <= cnt_q + 25'd1;
    end
  end
endmodule
`default_nettype wire

// *** hw/ocs_pix_colour.v ***
`default_nettype none
module ocs_pix_colour (
  input wire special, // Cell holds a two-plane character
  input wire plane_a, // Plane 0 pixel
  input wire plane_b, // Plane 1 pixel
  input wire bank, // Foreground bank
  input wire [2:0] fg, // Foreground index in bank
  output reg is_fg, // Pixel is foreground-coded
  output reg [3:0] colour // Foreground colour entry
);
  // Plane decode; plain characters use plane 0 only
  always @*
  begin
    is_fg = plane_a;
    colour = {bank, fg};
    if (special)
    begin
      is_fg = plane_a | plane_b;
      case ({plane_b, plane_a})
        2'b10: colour = {bank, 3'h6};
        2'b11: colour = {bank, 3'h7};
        default: colour = {bank, fg};
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hw/ocs_compositor.v ***
// Decided for this implementation: the register offsets and strobed register access.
`include "ocs_regs.vh"
`default_nettype none
module ocs_compositor #(
  parameter ADDR_W = 10, // Display memory address width
  parameter [24:0] FLASH_SLOW_CYC = `OCS_FLASH_SLOW_CYC,
  parameter [24:0] FLASH_FAST_CYC = `OCS_FLASH_FAST_CYC
) (
  input wire sys_clk, // Pixel clock, 40 MHz
  input wire sys_rst, // Async reset, high
  input wire ce, // Clock enable, low freezes all
  input wire [2:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  output reg [7:0] reg_rdata_q, // Read data, cycle after strobe
  input wire frame_start, // Pulse: page restarts at address 0
  input wire row_start, // Pulse: new text row begins
  input wire word_valid, // Display word present
  input wire [11:0] word, // Display memory word
  output reg [ADDR_W-1:0] mem_addr_q, // Next word address
  output reg row_done_q, // Row ended, words ignored
  output reg [7:0] font_code_q, // Font slot of current cell
  output reg special_q, // Current cell is two-plane
  output reg dwidth_q, // Double width active
  output reg dheight_q, // Double height active
  output reg italic_q, // Italics active for cell
  input wire pix_valid, // Pixel inside text area
  input wire special_char_plane_a, // Plane 0 pixel
  input wire special_char_plane_b, // Plane 1 pixel
  input wire [3:0] nbr_fg, // Neighbour fg: N,S,E,W
  input wire top_line, // Top scan-line of cell
  input wire bottom_line, // Bottom scan-line of cell
  output reg [3:0] colour_q, // Colour table index out
  output reg rgb_black_q, // Force RGB true black
  output reg fast_blanking_out // 1 = RGB, 0 = video
);
  // Software-visible settings
  reg [7:0] disp_q; // Mode, screen colour, flash rate
  reg [7:0] fringe_q; // Fringe directions and colour
  reg [7:0] ta_start_q; // Text area start position
  reg [7:0] ta_end_q; // Text area end position
  wire [1:0] screen_mode_sel; // Display mode field
  wire screen_mode_sel_lo; // Mode bit 0
  wire screen_mode_sel_hi; // Mode bit 1
  wire [3:0] screen_colour_sel; // Screen colour
  wire flash_rate_sel; // Flash rate
  wire [3:0] fringe_direction_enable; // N,S,E,W enables
  wire [3:0] fringe_colour_sel; // Fringe colour
  assign screen_mode_sel_lo = disp_q[`OCS_DISP_MODE_LSB];
  assign screen_mode_sel_hi = disp_q[`OCS_DISP_MODE_LSB+1];
  assign screen_mode_sel = {screen_mode_sel_hi, screen_mode_sel_lo};
  assign screen_colour_sel = disp_q[`OCS_DISP_SCR_LSB+3:`OCS_DISP_SCR_LSB];
  assign flash_rate_sel = disp_q[`OCS_DISP_FLF_BIT];
  assign fringe_direction_enable = fringe_q[`OCS_FR_DIR_LSB+3:0];
  assign fringe_colour_sel = fringe_q[`OCS_FR_COL_LSB+3:`OCS_FR_COL_LSB];

  // Serial attribute state for the row
  reg [3:0] bg_q; // Background colour
  reg bank_q; // Foreground bank
  reg ul_q; // Underline
  reg ol_q; // Overline
  reg box_q; // Boxing
  reg flash_q; // Flash
  reg ital_q; // Italics
  reg frg_q; // Fringing
  reg bgd_q; // Background duration
  // Set-after attributes waiting for next character
  reg pend_q; // Pending values held
  reg [3:0] p_bg_q; // Pending background
  reg p_bank_q; // Pending bank
  reg p_ul_q; // Pending underline
  reg p_ol_q; // Pending overline
  reg p_box_q; // Pending box mode
  // Latched cell used by the pixel path
  reg [2:0] c_fg_q; // Cell foreground index
  reg [3:0] c_bg_q; // Cell background
  reg c_bank_q; // Cell bank
  reg c_ul_q; // Cell underline
  reg c_ol_q; // Cell overline
  reg c_box_q; // Cell boxing
  reg c_flash_q; // Cell flash
  reg c_frg_q; // Cell fringing
  reg c_space_q; // Cell renders as space
  reg fill_q; // Background runs to area end
  reg [7:0] pos_q; // Characters in this row

  // Effective state after applying pending set-after values
  reg [3:0] e_bg; // Effective background
  reg e_bank; // Effective bank
  reg e_ul; // Effective underline
  reg e_ol; // Effective overline
  reg e_box; // Effective box
  always @*
  begin
    e_bg = bg_q;
    e_bank = bank_q;
    e_ul = ul_q;
    e_ol = ol_q;
    e_box = box_q;
    if (pend_q)
    begin
      e_bg = p_bg_q;
      e_bank = p_bank_q;
      e_ul = p_ul_q;
      e_ol = p_ol_q;
      e_box = p_box_q;
    end
  end

  wire [7:0] span_w; // Row capacity from text area
  wire take_w; // Word accepted this cycle
  wire is_serial; // Serial attribute word
  wire is_mode1; // Serial mode 1 word
  wire first_pos; // Word at first character position
  wire [7:0] code_w; // Parallel character code
  wire flash_ph; // 1 = flashing pixels shown
  assign span_w = ta_end_q - ta_start_q;
  assign take_w = word_valid & ~row_done_q;
  assign is_serial = word[`OCS_W_SERIAL];
  assign is_mode1 = word[`OCS_W_SMODE];
  assign first_pos = (pos_q == 8'h00);
  assign code_w = word[7:0];

  // Register writes and registered read data
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      disp_q <= `OCS_DISP_RST;
      fringe_q <= `OCS_FRINGE_RST;
      ta_start_q <= `OCS_TA_START_RST;
      ta_end_q <= `OCS_TA_END_RST;
      reg_rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `OCS_REG_DISP: disp_q <= reg_wdata;
          `OCS_REG_FRINGE: fringe_q <= reg_wdata;
          `OCS_REG_TA_START: ta_start_q <= reg_wdata;
          `OCS_REG_TA_END: ta_end_q <= reg_wdata;
          default: ;
        endcase
      end
      // Read data stand only in the cycle after the strobe
      reg_rdata_q <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `OCS_REG_DISP: reg_rdata_q <= disp_q;
          `OCS_REG_FRINGE: reg_rdata_q <= fringe_q;
          `OCS_REG_TA_START: reg_rdata_q <= ta_start_q;
          `OCS_REG_TA_END: reg_rdata_q <= ta_end_q;
          `OCS_REG_STATUS: reg_rdata_q <= {6'h00, flash_ph, row_done_q};
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Word decode and row attribute state
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_addr_q <= {ADDR_W{1'b0}};
      row_done_q <= 1'b0;
      pos_q <= 8'h00;
      bg_q <= `OCS_DEF_BG;
      bank_q <= 1'b0;
      ul_q <= 1'b0;
      ol_q <= 1'b0;
      box_q <= 1'b0;
      flash_q <= 1'b0;
      ital_q <= 1'b0;
      frg_q <= 1'b0;
      bgd_q <= 1'b0;
      dwidth_q <= 1'b0;
      dheight_q <= 1'b0;
      pend_q <= 1'b0;
      p_bg_q <= `OCS_DEF_BG;
      p_bank_q <= 1'b0;
      p_ul_q <= 1'b0;
      p_ol_q <= 1'b0;
      p_box_q <= 1'b0;
      fill_q <= 1'b0;
      font_code_q <= 8'h00;
      special_q <= 1'b0;
      italic_q <= 1'b0;
      c_fg_q <= `OCS_DEF_FG;
      c_bg_q <= `OCS_DEF_BG;
      c_bank_q <= 1'b0;
      c_ul_q <= 1'b0;
      c_ol_q <= 1'b0;
      c_box_q <= 1'b0;
      c_flash_q <= 1'b0;
      c_frg_q <= 1'b0;
      c_space_q <= 1'b1;
    end
    else if (ce)
    begin
      if (frame_start)
        mem_addr_q <= {ADDR_W{1'b0}};
      else if (take_w)
        mem_addr_q <= mem_addr_q + 1'b1;
      if (row_start)
      begin
        // Every row attribute back to its default; the latched cell keeps its values except c_fg_q and c_space_q
        pos_q <= 8'h00;
        row_done_q <= 1'b0;
        bg_q <= `OCS_DEF_BG;
        bank_q <= 1'b0;
        ul_q <= 1'b0;
        ol_q <= 1'b0;
        box_q <= 1'b0;
        flash_q <= 1'b0;
        ital_q <= 1'b0;
        frg_q <= 1'b0;
        bgd_q <= 1'b0;
        dwidth_q <= 1'b0;
        dheight_q <= 1'b0;
        pend_q <= 1'b0;
        c_fg_q <= `OCS_DEF_FG;
        fill_q <= 1'b0;
        c_space_q <= 1'b1;
      end
      else if (take_w)
      begin
        pos_q <= pos_q + 8'd1;
        // Capacity limit closes the row
        if (pos_q + 8'd1 >= span_w)
          row_done_q <= 1'b1;
        // Set-after values become current at this character
        bg_q <= e_bg;
        bank_q <= e_bank;
        ul_q <= e_ul;
        ol_q <= e_ol;
        box_q <= e_box;
        pend_q <= 1'b0;
        c_bg_q <= e_bg;
        c_bank_q <= e_bank;
        c_ul_q <= e_ul;
        c_ol_q <= e_ol;
        c_box_q <= e_box;
        c_flash_q <= flash_q;
        c_frg_q <= frg_q;
        italic_q <= ital_q;
        c_space_q <= is_serial;
        font_code_q <= code_w;
        special_q <= 1'b0;
        if (!is_serial)
        begin
          // Serial cells keep this colour for their lines
          c_fg_q <= word[10:8];
          // Columns 8 and 9: two-plane, even slot only
          if (code_w[7:5] == 3'h4)
          begin
            special_q <= 1'b1;
            font_code_q <= {code_w[7:1], 1'b0};
          end
          // Columns B and C reach the slots of columns 8 and 9 as plain glyphs
          else if (code_w[7:4] == 4'hB || code_w[7:4] == 4'hC)
            font_code_q <= code_w - 8'h30;
        end
        else if (!is_mode1)
        begin
          // Mode 0 takes effect at its own position
          bg_q <= word[3:0];
          box_q <= word[6];
          ul_q <= word[4];
          ol_q <= word[5];
          flash_q <= word[7];
          ital_q <= word[8];
          frg_q <= word[9];
          c_bg_q <= word[3:0];
          c_box_q <= word[6];
          c_ul_q <= word[4];
          c_ol_q <= word[5];
          c_flash_q <= word[7];
          c_frg_q <= word[9];
          italic_q <= word[8];
        end
        else
        begin
          bgd_q <= word[8];
          if (word[9])
          begin
            row_done_q <= 1'b1;
            fill_q <= word[8];
          end
          if (first_pos)
          begin
            // First position: everything applies now
            bg_q <= word[3:0];
            box_q <= word[6];
            dwidth_q <= word[4];
            dheight_q <= word[5];
            bank_q <= word[7];
            c_bg_q <= word[3:0];
            c_box_q <= word[6];
            c_bank_q <= word[7];
          end
          else
          begin
            // Later positions: held for the next character
            pend_q <= 1'b1;
            p_bg_q <= word[3:0];
            p_ul_q <= word[4];
            p_ol_q <= word[5];
            p_box_q <= word[6];
            p_bank_q <= word[7];
          end
        end
      end
    end
  end

  // Flash phase generator
  ocs_flash_timer #(
    .SLOW_CYC(FLASH_SLOW_CYC),
    .FAST_CYC(FLASH_FAST_CYC)
  ) u_flash (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .fast(flash_rate_sel),
    .phase_q(flash_ph)
  );

  // Plane to colour mapping
  wire glyph_fg; // Pixel is foreground-coded
  wire [3:0] fg_col; // Foreground colour entry
  ocs_pix_colour u_col (
    .special(special_q),
    .plane_a(special_char_plane_a & ~c_space_q),
    .plane_b(special_char_plane_b & ~c_space_q & special_q),
    .bank(c_bank_q),
    .fg(c_fg_q),
    .is_fg(glyph_fg),
    .colour(fg_col)
  );

  // Pixel classification
  reg draw_fg; // Foreground pixel drawn
  reg draw_frg; // Fringe pixel drawn
  reg draw_bg; // Background pixel drawn
  reg [3:0] mix_col; // Colour when something is drawn
  always @*
  begin
    // Lines cover spaces too; after a filled row end no glyph
    draw_fg = pix_valid & (((glyph_fg & ~fill_q) &
      (~c_flash_q | flash_ph)) | (c_ul_q & bottom_line) |
      (c_ol_q & top_line));
    // Two-plane glyphs are never fringed
    draw_frg = pix_valid & c_frg_q & ~special_q & ~fill_q & ~glyph_fg &
      (|(nbr_fg & fringe_direction_enable));
    // Boxing only matters outside full text mode
    draw_bg = pix_valid & ((screen_mode_sel == `OCS_MODE_TEXT) |
      c_box_q);
    if (draw_fg)
      mix_col = fg_col;
    else if (draw_frg)
      mix_col = fringe_colour_sel;
    else
      mix_col = c_bg_q;
  end

  // Screen compositor, registered outputs
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      colour_q <= 4'h0;
      rgb_black_q <= 1'b1;
      fast_blanking_out <= 1'b0;
    end
    else if (ce)
    begin
      case (screen_mode_sel)
        `OCS_MODE_VIDEO:
        begin
          colour_q <= 4'h0;
          rgb_black_q <= 1'b1;
          fast_blanking_out <= 1'b0;
        end
        `OCS_MODE_TEXT, `OCS_MODE_MIXSCR:
        begin
          // Screen colour fills the full width elsewhere
          rgb_black_q <= 1'b0;
          fast_blanking_out <= 1'b1;
          if (draw_fg | draw_frg | draw_bg)
            colour_q <= mix_col;
          else
            colour_q <= screen_colour_sel;
        end
        default:
        begin
          // Transparent screen: video where nothing drawn
          rgb_black_q <= 1'b0;
          colour_q <= mix_col;
          fast_blanking_out <= draw_fg | draw_frg | draw_bg;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/ocs_compositor_sva.sv ***
`default_nettype none
module ocs_compositor_sva #(
  parameter ADDR_W = 10 // Display memory address width
) (
  input wire logic sys_clk, // Pixel clock
  input wire logic sys_rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic [2:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic frame_start, // Page restart
  input wire logic row_start, // Row restart
  input wire logic word_valid, // Word offered
  input wire logic [11:0] word, // Display word
  input wire logic [ADDR_W-1:0] mem_addr_q, // Word address
  input wire logic row_done_q, // Row ended
  input wire logic [7:0] font_code_q, // Font slot
  input wire logic special_q, // Two-plane cell
  input wire logic pix_valid, // Inside text area
  input wire logic [3:0] colour_q, // Colour index
  input wire logic rgb_black_q, // True black
  input wire logic fast_blanking_out // 1 RGB, 0 video
);
  logic [7:0] disp_s; // Shadow of display control
  wire logic [7:0] w_code = word[7:0]; // Code field, whole for $past
  wire logic [1:0] mode_s = disp_s[1:0]; // Screen display mode
  wire logic [3:0] scr_s = disp_s[5:2]; // Screen colour
  // Plain word that really gets latched; serial words excluded
  wire logic take_par = ce && word_valid && !row_done_q && !row_start
    && !word[11];

  // Shadow follows bus writes so modes can be judged from ports alone
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      disp_s <= 8'h00;
    else if (ce && reg_wr && reg_addr == 3'h0)
      disp_s <= reg_wdata;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  video_black_a: assert property (ce && mode_s == 2'h0 && $stable(disp_s)
    |=> rgb_black_q && !fast_blanking_out && colour_q == 4'h0)
    else $error("video mode not black");
  screen_fill_a: assert property (ce && !pix_valid && $stable(disp_s)
    && (mode_s == 2'h1 || mode_s == 2'h2)
    |=> fast_blanking_out && colour_q == $past(scr_s))
    else $error("screen colour missing");
  video_pass_a: assert property (ce && !pix_valid && mode_s == 2'h3
    && $stable(disp_s) |=> !fast_blanking_out && !rgb_black_q)
    else $error("video not passed");
  addr_step_a: assert property (ce && word_valid && !row_done_q
    && !frame_start |=> mem_addr_q == $past(mem_addr_q) + 1'b1)
    else $error("address not advanced");
  addr_restart_a: assert property (ce && frame_start
    |=> mem_addr_q == '0)
    else $error("address not restarted");
  refuse_word_a: assert property (ce && row_done_q && !frame_start
    && !row_start |=> $stable(mem_addr_q))
    else $error("word taken after row end");
  row_clear_a: assert property (ce && row_start |=> !row_done_q)
    else $error("row end not cleared");
  plain_code_a: assert property (take_par && !word[7]
    |=> !special_q && font_code_q == $past(w_code))
    else $error("plain code wrong");
  special_code_a: assert property (take_par && word[7:5] == 3'h4
    |=> special_q && font_code_q == ($past(w_code) & 8'hFE))
    else $error("special slot wrong");
  alt_column_a: assert property (take_par && word[7:0] >= 8'hB0
    && word[7:0] <= 8'hCF
    |=> !special_q && font_code_q == $past(w_code) - 8'h30)
    else $error("alternate column wrong");

  cover property ($rose(row_done_q));
  cover property (ce && special_q && pix_valid);
  cover property (ce && mode_s == 2'h3 && pix_valid ##1 fast_blanking_out);
endmodule

bind ocs_compositor ocs_compositor_sva #(.ADDR_W(ADDR_W)) u_sva (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .frame_start(frame_start),
  .row_start(row_start), .word_valid(word_valid), .word(word),
  .mem_addr_q(mem_addr_q), .row_done_q(row_done_q),
  .font_code_q(font_code_q), .special_q(special_q), .pix_valid(pix_valid),
  .colour_q(colour_q), .rgb_black_q(rgb_black_q),
  .fast_blanking_out(fast_blanking_out)
);
`default_nettype wire

// *** tb/tb_ocs_compositor.sv ***
`default_nettype none
`include "ocs_regs.vh"
module tb_ocs_compositor;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, ce; // Clock, reset, enable
  logic [2:0] reg_addr; // Register port
  logic [7:0] reg_wdata, reg_rdata_q, d;
  logic reg_wr, reg_rd;
  logic frame_start, row_start, word_valid; // Word path
  logic [11:0] word;
  logic [9:0] mem_addr_q, a0;
  logic row_done_q, special_q, dwidth_q, dheight_q, italic_q;
  logic [7:0] font_code_q;
  logic pix_valid, plane_a, plane_b, top_line, bottom_line; // Pixel path
  logic [3:0] nbr_fg, colour_q;
  logic rgb_black_q, fast_blanking_out;
  int miscompares = 0; // Mismatch count
  int num_checks = 0; // Comparison count
  logic [3:0] sp_tab [4] = '{4'h8, 4'h1, 4'h6, 4'h7}; // Plane colours

  // Short flash counts keep the run brief
  ocs_compositor #(.ADDR_W(10), .FLASH_SLOW_CYC(25'd8),
    .FLASH_FAST_CYC(25'd4)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .frame_start(frame_start),
    .row_start(row_start), .word_valid(word_valid), .word(word),
    .mem_addr_q(mem_addr_q), .row_done_q(row_done_q),
    .font_code_q(font_code_q), .special_q(special_q), .dwidth_q(dwidth_q),
    .dheight_q(dheight_q), .italic_q(italic_q), .pix_valid(pix_valid),
    .special_char_plane_a(plane_a), .special_char_plane_b(plane_b),
    .nbr_fg(nbr_fg), .top_line(top_line), .bottom_line(bottom_line),
    .colour_q(colour_q), .rgb_black_q(rgb_black_q),
    .fast_blanking_out(fast_blanking_out));

  // Free-running pixel clock, 25 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Compare and report at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Verdict in one place
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata_q;
  endtask

  // Offer one display word for one edge
  task automatic put(input logic [11:0] w);
    @(posedge sys_clk);
    word <= w;
    word_valid <= 1'b1;
    @(posedge sys_clk);
    word_valid <= 1'b0;
    #1;
  endtask

  // Row or frame start pulse
  task automatic pulse(input logic fr);
    @(posedge sys_clk);
    if (fr)
      frame_start <= 1'b1;
    else
      row_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    row_start <= 1'b0;
    #1;
  endtask

  // One pixel; colour is only judged where RGB is expected
  task automatic pix(input logic pv, input logic [1:0] pl,
    input logic [1:0] ln, input logic [3:0] nb, input logic [3:0] ec,
    input logic ef);
    @(posedge sys_clk);
    pix_valid <= pv;
    {plane_b, plane_a} <= pl;
    {top_line, bottom_line} <= ln;
    nbr_fg <= nb;
    @(posedge sys_clk);
    #1;
    chk({7'h0, fast_blanking_out}, {7'h0, ef}, "blanking");
    if (ef)
      chk({4'h0, colour_q}, {4'h0, ec}, "colour");
  endtask

  // Cycles between two flash phase changes, seen through status bit 1
  task automatic flash_half(input logic [7:0] exp);
    logic p;
    logic [7:0] n;
    @(posedge sys_clk);
    reg_addr <= `OCS_REG_STATUS;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    #1;
    p = reg_rdata_q[1];
    for (int k = 0; k < 2; k++)
    begin
      n = 8'h00;
      while (reg_rdata_q[1] === p && n < 8'd40)
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      p = reg_rdata_q[1];
    end
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    chk(n, exp, "flash half");
    if (n == 8'd40)
      end_of_test();
  endtask

  initial
  begin
    {ce, sys_rst} = 2'b11;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {frame_start, row_start, word_valid, word} = '0;
    {pix_valid, plane_a, plane_b, top_line, bottom_line, nbr_fg} = '0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values and unmapped places; status skipped as it moves
    wr(3'h6, 8'hFF);
    for (int i = 0; i < 8; i++)
      if (i != 4)
      begin
        rd(i[2:0], d);
        chk(d, (i == 3) ? `OCS_TA_END_RST : 8'h00, "reset value");
      end
    pix(1, 2'h1, 2'h0, 4'h0, 4'h0, 0);
    chk({7'h0, rgb_black_q}, 8'h01, "true black");
    $display("reset and video test done");
    // Full text mode, screen colour 5
    wr(`OCS_REG_DISP, 8'h15);
    pix(0, 2'h0, 2'h0, 4'h0, 4'h5, 1);
    pulse(0);
    put(12'h541);
    chk(font_code_q, 8'h41, "code");
    pix(1, 2'h1, 2'h0, 4'h0, 4'h5, 1);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h8, 1);
    // Serial mode 1 at first and later positions
    pulse(0);
    put(12'hCB3);
    chk({6'h0, dwidth_q, dheight_q}, 8'h03, "double size");
    put(12'h241);
    pix(1, 2'h1, 2'h0, 4'h0, 4'hA, 1);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h3, 1);
    put(12'hC05);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h3, 1);
    put(12'h241);
    pix(1, 2'h1, 2'h0, 4'h0, 4'h2, 1);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h5, 1);
    pulse(0);
    chk({6'h0, dwidth_q, dheight_q}, 8'h00, "size default");
    put(12'h041);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h8, 1);
    // Serial mode 0: lines, italics, cell shown as a space
    put(12'h932);
    chk({7'h0, italic_q}, 8'h01, "italics");
    pix(1, 2'h1, 2'h0, 4'h0, 4'h2, 1);
    pix(1, 2'h0, 2'h2, 4'h0, 4'h0, 1);
    pix(1, 2'h0, 2'h1, 4'h0, 4'h0, 1);
    $display("attribute test done");
    // Fringe north only, colour C
    wr(`OCS_REG_FRINGE, 8'hC1);
    pulse(0);
    put(12'hA01);
    put(12'h341);
    pix(1, 2'h0, 2'h0, 4'h1, 4'hC, 1);
    pix(1, 2'h0, 2'h0, 4'h2, 4'h1, 1);
    pix(1, 2'h1, 2'h0, 4'h1, 4'h3, 1);
    // Two-plane cell and its alternate column
    pulse(0);
    put(12'h181);
    chk({special_q, font_code_q[6:0]}, 8'h80, "special");
    for (int i = 0; i < 4; i++)
      pix(1, i[1:0], 2'h0, 4'h0, sp_tab[i], 1);
    put(12'h0B5);
    chk({special_q, font_code_q[6:0]}, 8'h05, "alt column");
    $display("fringe and special test done");
    // Mixed screen then mixed video, boxed and unboxed
    wr(`OCS_REG_DISP, 8'h16);
    pulse(0);
    put(12'h141);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h5, 1);
    pix(1, 2'h1, 2'h0, 4'h0, 4'h1, 1);
    put(12'h843);
    put(12'h141);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h3, 1);
    wr(`OCS_REG_DISP, 8'h17);
    pulse(0);
    put(12'h181);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h0, 0);
    pix(1, 2'h1, 2'h0, 4'h0, 4'h1, 1);
    put(12'h840);
    put(12'h181);
    pix(1, 2'h0, 2'h0, 4'h0, 4'h0, 1);
    $display("mixed mode test done");
    // Flash rate, slow then fast
    flash_half(8'd8);
    wr(`OCS_REG_DISP, 8'h55);
    flash_half(8'd4);
    $display("flash test done");
    // Row capacity, end-of-row word, frame restart
    wr(`OCS_REG_TA_END, 8'h03);
    pulse(0);
    repeat (3) put(12'h041);
    chk({7'h0, row_done_q}, 8'h01, "row full");
    a0 = mem_addr_q;
    put(12'h041);
    chk(mem_addr_q[7:0], a0[7:0], "refused word");
    pulse(0);
    chk({7'h0, row_done_q}, 8'h00, "row reopened");
    put(12'hE00);
    chk({7'h0, row_done_q}, 8'h01, "end of row");
    pulse(1);
    pulse(0);
    chk(mem_addr_q[7:0], 8'h00, "page restart");
    put(12'h041);
    chk(mem_addr_q[7:0], 8'h01, "next address");
    // Enable low must freeze the address counter
    @(posedge sys_clk) ce <= 1'b0;
    put(12'h041);
    chk(mem_addr_q[7:0], 8'h01, "frozen address");
    @(posedge sys_clk) ce <= 1'b1;
    $display("row test done");
    end_of_test();
  end
endmodule
`default_nettype wire
